// [common/eaci_consts.svh]
`ifndef EACI_CONSTS_SVH
`define EACI_CONSTS_SVH
`define EACI_OFF_CTL1  8'h00
`define EACI_OFF_CTL2  8'h04
`define EACI_OFF_CTL3  8'h08
`define EACI_OFF_STAT  8'h0c
`define EACI_OFF_CPE   8'h10
`define EACI_OFF_ISTS  8'h14
`define EACI_OFF_IMSK  8'h18
`define EACI_RST_CTL1  8'h00
`define EACI_RST_CTL2  8'h7f
`define EACI_RST_CTL3  8'hc0
`define EACI_RST_STAT  8'h7c
`define EACI_WM_CTL1   8'hf8
`define EACI_WM_CTL2   8'h7f
`define EACI_WM_CTL3   8'hf8
`define EACI_WM_STAT   8'hf3
`define EACI_C1_GIE    7
`define EACI_C1_GIEL   6
`define EACI_C1_T0E    5
`define EACI_C1_X0E    4
`define EACI_C1_PCE    3
`define EACI_C2_T0P    2
`define EACI_C2_X3P    1
`define EACI_C2_PCP    0
`define EACI_C3_X2P    7
`define EACI_C3_X1P    6
`define EACI_C3_X3E    5
`define EACI_C3_X2E    4
`define EACI_C3_X1E    3
`define EACI_ST_PLE    7
`define EACI_ST_CM     5
`define EACI_EV_T0     4
`define EACI_EV_PC     5
`define EACI_PRIME     2'h3
`define EACI_T0_MAX8   8'hff
`define EACI_T0_MAX16  16'hffff
`define EACI_STK_DEPTH 4'h8
`define EACI_PC_W      21
`endif

// [common/eaci_pkg.sv]
package eaci_pkg;
	typedef enum logic [2:0] {
		st_run   = 3'b001,
		st_sleep = 3'b010,
		st_wake  = 3'b100
	} eaci_state_e;
	typedef struct packed {
		logic [7:0] working_register;
		logic [7:0] status;
		logic [7:0] bank_select_register;
	} eaci_ctx_s;
	typedef logic [5:0] eaci_ev_t;
endpackage

// [hdl/eaci_top.sv]
`timescale 1ns/1ns
`include "eaci_consts.svh"
// How it works
// - Priority enable bit selects two-level or single-level
// - Mismatch reset clears flag; software sets back
// - Timeout and power-down bits read-only, one
// - Edge select picks rising or falling trigger
// - Valid edge sets flag regardless of enable
// - Enabled external sources wake from sleep
// - Wake vectors only with global enable set
// - External one to three follow priority bits
// - External zero is always high priority
// - Timer rollover sets overflow flag, both widths
// - Timer interrupt gated by enable, own priority
// - Port-B upper pin change sets change flag
// - Per-pin change enables, low nibble reads zero
// - Pin enables need port-change enable too
// - Port-change priority follows its own bit
// - Entry pushes return address, saves context
module eaci_top
(
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [7:0]             port_b_pins,
	input  wire logic [15:0]            timer_zero_count,
	input  wire logic                   timer0_wide_mode,
	input  wire logic                   cfg_mismatch_evt,
	input  wire logic                   watchdog_timeout_evt,
	input  wire logic                   watchdog_clear_evt,
	input  wire logic                   power_down_evt,
	input  wire logic                   core_sleeping,
	input  wire logic                   vector_taken,
	input  wire logic                   vector_is_high,
	input  wire logic                   return_taken,
	input  wire logic                   return_is_high,
	input  wire logic [`EACI_PC_W-1:0]  return_pc,
	input  wire eaci_pkg::eaci_ctx_s    core_ctx,
	output logic                        irq_high,
	output logic                        irq_low,
	output logic                        wake,
	output logic                        wake_vector,
	output eaci_pkg::eaci_ctx_s         fast_ctx,
	output logic [`EACI_PC_W-1:0]       stack_top,
	output logic                        stack_full,
	output logic                        irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ****************************************
	// Register bus
	// ****************************************
	logic                  acc;
	logic                  hit;
	logic                  wr;
	logic [7:0]            ctl1;
	logic [7:0]            ctl2;
	logic [7:0]            ctl3;
	logic [7:0]            stat;
	logic                  to_flag;
	logic                  pd_flag;
	logic [3:0]            cpe;
	eaci_pkg::eaci_ev_t    flag;
	eaci_pkg::eaci_ev_t    ists;
	eaci_pkg::eaci_ev_t    imsk;
	logic [7:0]            rd_mux;

	assign acc = psel && penable;
	assign pready = 1'b1;
	assign wr = acc && pwrite && hit;
	assign pslverr = acc && !hit;

	always_comb
	begin
		hit = 1'b1;
		rd_mux = 8'h00;
		case (paddr)
			`EACI_OFF_CTL1: rd_mux = {ctl1[7:3], flag[`EACI_EV_T0],
				flag[0], flag[`EACI_EV_PC]};
			`EACI_OFF_CTL2: rd_mux = ctl2;
			`EACI_OFF_CTL3: rd_mux = {ctl3[7:3], flag[3:1]};
			`EACI_OFF_STAT: rd_mux = {stat[7:4], to_flag, pd_flag,
				stat[1:0]};
			`EACI_OFF_CPE:  rd_mux = {cpe, 4'h0};
			`EACI_OFF_ISTS: rd_mux = {2'h0, ists};
			`EACI_OFF_IMSK: rd_mux = {2'h0, imsk};
			default:        hit = 1'b0;
		endcase
	end

	// Read data is latched in the setup phase, ready in the access phase
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= {24'h00_0000, rd_mux};
	end

	// ****************************************
	// Control registers
	// ****************************************
	logic wr_c1;
	logic wr_c3;
	logic ple;

	assign wr_c1 = wr && (paddr == `EACI_OFF_CTL1);
	assign wr_c3 = wr && (paddr == `EACI_OFF_CTL3);
	assign ple = stat[`EACI_ST_PLE];

	// Global enables drop on vector entry and return on exit
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ctl1 <= `EACI_RST_CTL1;
		else if (vector_taken)
		begin
			if (vector_is_high || !ple)
				ctl1[`EACI_C1_GIE] <= 1'b0;
			else
				ctl1[`EACI_C1_GIEL] <= 1'b0;
		end
		else if (return_taken)
		begin
			if (return_is_high || !ple)
				ctl1[`EACI_C1_GIE] <= 1'b1;
			else
				ctl1[`EACI_C1_GIEL] <= 1'b1;
		end
		else if (wr_c1)
			ctl1 <= pwdata[7:0] & `EACI_WM_CTL1;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ctl2 <= `EACI_RST_CTL2;
		else if (wr && (paddr == `EACI_OFF_CTL2))
			ctl2 <= pwdata[7:0] & `EACI_WM_CTL2;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ctl3 <= `EACI_RST_CTL3;
		else if (wr_c3)
			ctl3 <= pwdata[7:0] & `EACI_WM_CTL3;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			cpe <= 4'h0;
		else if (wr && (paddr == `EACI_OFF_CPE))
			cpe <= pwdata[7:4];
	end

	// ****************************************
	// Reset-cause status
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			stat <= `EACI_RST_STAT;
		else
		begin
			if (wr && (paddr == `EACI_OFF_STAT))
				stat <= pwdata[7:0] & `EACI_WM_STAT;
			if (cfg_mismatch_evt)
				stat[`EACI_ST_CM] <= 1'b0;
		end
	end

	// Bus writes never reach these two bits
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			to_flag <= 1'b1;
			pd_flag <= 1'b1;
		end
		else
		begin
			if (watchdog_timeout_evt)
				to_flag <= 1'b0;
			else if (watchdog_clear_evt || power_down_evt)
				to_flag <= 1'b1;
			if (power_down_evt)
				pd_flag <= 1'b0;
			else if (watchdog_clear_evt)
				pd_flag <= 1'b1;
		end
	end

	AST_CM_CLEAR: assert property (
		cfg_mismatch_evt |=> !stat[`EACI_ST_CM])
		else $error("mismatch flag not cleared");

	AST_TO_PD_RO: assert property (
		(wr && paddr == `EACI_OFF_STAT && !watchdog_timeout_evt &&
		!watchdog_clear_evt && !power_down_evt)
		|=> $stable({to_flag, pd_flag}))
		else $error("read-only status bits changed by write");

	// ****************************************
	// Event detection
	// ****************************************
	logic [7:0]         pin_s1;
	logic [7:0]         pin_s2;
	logic [7:0]         pin_s3;
	logic [1:0]         prime;
	logic               primed;
	logic [3:0]         esel;
	logic [3:0]         ext_ev;
	logic               pc_ev;
	logic [15:0]        t0_prev;
	logic               t0_ovf;
	eaci_pkg::eaci_ev_t ev;

	// Two-flop synchroniser plus one stage of history
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pin_s1 <= 8'h00;
			pin_s2 <= 8'h00;
			pin_s3 <= 8'h00;
		end
		else
		begin
			pin_s1 <= port_b_pins;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// Masks the false edge while the history fills after reset
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			prime <= 2'h0;
		else if (!primed)
			prime <= prime + 2'h1;
	end

	assign primed = (prime == `EACI_PRIME);
	assign esel = {ctl2[3], ctl2[4], ctl2[5], ctl2[6]};
	assign ext_ev = (esel & pin_s2[3:0] & ~pin_s3[3:0]) |
		(~esel & ~pin_s2[3:0] & pin_s3[3:0]);
	assign pc_ev = |((pin_s2[7:4] ^ pin_s3[7:4]) & cpe);

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			t0_prev <= 16'h0000;
		else
			t0_prev <= timer_zero_count;
	end

	always_comb
	begin
		if (timer0_wide_mode)
			t0_ovf = (t0_prev == `EACI_T0_MAX16) &&
				(timer_zero_count == 16'h0000);
		else
			t0_ovf = (t0_prev[7:0] == `EACI_T0_MAX8) &&
				(timer_zero_count[7:0] == 8'h00);
	end

	assign ev = {pc_ev && primed, t0_ovf, ext_ev & {4{primed}}};

	AST_EXT_RISE: assert property (
		($rose(port_b_pins[0]) && esel[0] && primed)
		##1 (port_b_pins[0] && esel[0]) [*2] |=> flag[0])
		else $error("rising edge did not set flag");

	AST_T0_OVF8: assert property (
		(!timer0_wide_mode && $past(timer_zero_count[7:0]) == 8'hff &&
		timer_zero_count[7:0] == 8'h00) |=> flag[`EACI_EV_T0])
		else $error("8-bit rollover did not set flag");

	AST_PC_CHANGE: assert property (
		($changed(port_b_pins[7]) && cpe[3] && primed)
		##1 ($stable(port_b_pins[7]) && cpe[3]) [*2]
		|=> flag[`EACI_EV_PC])
		else $error("pin change did not set flag");

	// ****************************************
	// Flags and interrupt status
	// ****************************************
	eaci_pkg::eaci_ev_t flag_wm;
	eaci_pkg::eaci_ev_t flag_wd;

	assign flag_wm = {wr_c1, wr_c1, wr_c3, wr_c3, wr_c3, wr_c1};
	assign flag_wd = {pwdata[0], pwdata[2], pwdata[2], pwdata[1],
		pwdata[0], pwdata[1]};

	// A new event wins over a software clear in the same cycle
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			flag <= 6'h00;
		else
			flag <= ev | (flag_wm & flag_wd) | (~flag_wm & flag);
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ists <= 6'h00;
		else if (wr && (paddr == `EACI_OFF_ISTS))
			ists <= ev | (ists & ~pwdata[5:0]);
		else
			ists <= ev | ists;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			imsk <= 6'h00;
		else if (wr && (paddr == `EACI_OFF_IMSK))
			imsk <= pwdata[5:0];
	end

	assign irq = |(ists & imsk);

	AST_FLAG_HOLD: assert property (
		(flag[0] && !wr_c1) |=> flag[0])
		else $error("flag dropped without software clear");

	// ****************************************
	// Priority and requests
	// ****************************************
	eaci_pkg::eaci_ev_t en;
	eaci_pkg::eaci_ev_t pri;
	eaci_pkg::eaci_ev_t act;
	logic               global_interrupt_enable;
	logic               giel;

	assign en = {ctl1[`EACI_C1_PCE], ctl1[`EACI_C1_T0E],
		ctl3[`EACI_C3_X3E], ctl3[`EACI_C3_X2E], ctl3[`EACI_C3_X1E],
		ctl1[`EACI_C1_X0E]};
	assign pri = {ctl2[`EACI_C2_PCP], ctl2[`EACI_C2_T0P],
		ctl2[`EACI_C2_X3P], ctl3[`EACI_C3_X2P],
		ctl3[`EACI_C3_X1P], 1'b1};
	assign act = flag & en;
	assign global_interrupt_enable = ctl1[`EACI_C1_GIE];
	assign giel = ctl1[`EACI_C1_GIEL];

	always_comb
	begin
		if (ple)
		begin
			irq_high = global_interrupt_enable && |(act & pri);
			irq_low = global_interrupt_enable && giel && |(act & ~pri);
		end
		else
		begin
			irq_high = global_interrupt_enable && |act;
			irq_low = 1'b0;
		end
	end

	AST_COMPAT: assert property (
		!ple |-> !irq_low)
		else $error("low request in single-level mode");

	AST_X0_HIGH: assert property (
		(act[0] && global_interrupt_enable) |-> irq_high)
		else $error("external zero not high priority");

	AST_T0_LOW: assert property (
		(ple && global_interrupt_enable && giel && act == 6'b01_0000 &&
		!ctl2[`EACI_C2_T0P]) |-> (irq_low && !irq_high))
		else $error("timer low priority not honoured");

	// ****************************************
	// Wake-up from power-managed mode
	// ****************************************
	eaci_pkg::eaci_state_e state;
	eaci_pkg::eaci_state_e next_state;
	logic [3:0]            wake_en;
	logic                  wake_hit;

	assign wake_hit = |(flag[3:0] & wake_en);

	always_comb
	begin
		next_state = state;
		case (state)
			eaci_pkg::st_run:
				if (core_sleeping)
					next_state = eaci_pkg::st_sleep;
			eaci_pkg::st_sleep:
				if (!core_sleeping)
					next_state = eaci_pkg::st_run;
				else if (wake_hit)
					next_state = eaci_pkg::st_wake;
			eaci_pkg::st_wake:
				next_state = eaci_pkg::st_run;
			default:
				next_state = eaci_pkg::st_run;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			state <= eaci_pkg::st_run;
		else
			state <= next_state;
	end

	// Only enables that stand at sleep entry may wake
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			wake_en <= 4'h0;
		else if (state == eaci_pkg::st_run && core_sleeping)
			wake_en <= en[3:0];
	end

	assign wake = (state == eaci_pkg::st_wake);
	assign wake_vector = wake && global_interrupt_enable;

	AST_WAKE: assert property (
		(state == eaci_pkg::st_sleep && core_sleeping && wake_hit)
		|=> wake)
		else $error("enabled source did not wake core");

	AST_WAKE_NOVEC: assert property (
		(state == eaci_pkg::st_sleep && core_sleeping && wake_hit)
		##1 !global_interrupt_enable |-> (wake && !wake_vector))
		else $error("vectored on wake without global enable");

	// ****************************************
	// Context save
	// ****************************************
	logic [`EACI_PC_W-1:0] stk [0:7];
	logic [3:0]            sp;
	logic                  push;
	logic                  pop;
	logic [3:0]            sp_m2;

	assign stack_full = (sp == `EACI_STK_DEPTH);
	assign push = vector_taken && !stack_full;
	assign pop = return_taken && !vector_taken && (sp != 4'h0);
	assign sp_m2 = sp - 4'h2;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			sp <= 4'h0;
		else if (push)
			sp <= sp + 4'h1;
		else if (pop)
			sp <= sp - 4'h1;
	end

	always_ff @(posedge clk)
	begin
		if (push)
			stk[sp[2:0]] <= return_pc;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			stack_top <= '0;
		else if (push)
			stack_top <= return_pc;
		else if (pop)
			stack_top <= (sp >= 4'h2) ? stk[sp_m2[2:0]] : '0;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			fast_ctx <= '0;
		else if (vector_taken)
			fast_ctx <= core_ctx;
	end

	AST_CTX_SAVE: assert property (
		(vector_taken && !stack_full) |=>
		(stack_top == $past(return_pc) && fast_ctx == $past(core_ctx)))
		else $error("context not saved on entry");

	COV_WAKE_VEC: cover property (wake && wake_vector);
	COV_LOW_REQ: cover property (irq_low ##1 vector_taken);
	COV_CM: cover property (cfg_mismatch_evt ##[1:20] wr);
	COV_NEST: cover property (vector_taken ##[1:20] vector_taken);
endmodule // eaci_top

// [bench/eaci_core_model.sv]
`timescale 1ns/1ns
// ****************************************
// Core side: sleep, vectoring and return
// ****************************************
module eaci_core_model
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic irq_high,
	input  wire logic irq_low,
	input  wire logic wake,
	input  wire logic sleep_req,
	input  wire logic svc_en,
	input  wire logic ret_req,
	output logic      core_sleeping,
	output logic      vector_taken,
	output logic      vector_is_high,
	output logic      return_taken,
	output logic      return_is_high
);
	logic in_isr;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			core_sleeping <= 1'b0;
		else if (wake)
			core_sleeping <= 1'b0;
		else if (sleep_req)
			core_sleeping <= 1'b1;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			vector_taken   <= 1'b0;
			vector_is_high <= 1'b0;
			return_taken   <= 1'b0;
			return_is_high <= 1'b0;
			in_isr         <= 1'b0;
		end
		else
		begin
			vector_taken <= 1'b0;
			return_taken <= 1'b0;
			if (svc_en && !in_isr && !core_sleeping && (irq_high || irq_low))
			begin
				vector_taken   <= 1'b1;
				vector_is_high <= irq_high;
				in_isr         <= 1'b1;
			end
			else if (ret_req && in_isr && !vector_taken)
			begin
				return_taken   <= 1'b1;
				return_is_high <= vector_is_high;
				in_isr         <= 1'b0;
			end
		end
	end
endmodule // eaci_core_model

// [bench/tb_edge_and_change_interrupt_sources.sv]
`timescale 1ns/1ns
`include "eaci_consts.svh"
module tb_edge_and_change_interrupt_sources;
// ****************************************
// Harness
// ****************************************
	logic                clk = 1'b0;
	logic                sys_rst = 1'b1;
	logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]          paddr = 8'h00;
	logic [31:0]         pwdata = 32'h0, prdata, rd, seed = 32'hbeeb;
	logic                pready, pslverr, irq_high, irq_low, wake, irq;
	logic                wake_vector, stack_full, core_sleeping, err;
	logic                vector_taken, vector_is_high;
	logic                return_taken, return_is_high;
	logic [7:0]          port_b_pins = 8'h00, m;
	logic [15:0]         timer_zero_count = 16'h0;
	logic                timer0_wide_mode = 1'b0;
	logic [3:0]          evt = 4'h0;
	logic [20:0]         return_pc = 21'h0, stack_top, pc_exp;
	eaci_pkg::eaci_ctx_s core_ctx = '0, fast_ctx;
	logic [23:0]         ctx_exp;
	logic                sleep_req = 1'b0, svc_en = 1'b0, ret_req = 1'b0;
	logic                p, eh, el;
	int                  mismatches = 0, tests_run = 0;
	int                  nw = 0, nv = 0, nvt = 0, n0, v0;
	logic [7:0]  m1 [6] = '{8'h12, 8'h00, 8'h00, 8'h00, 8'h24, 8'h09};
	logic [7:0]  m3 [6] = '{8'h00, 8'h09, 8'h12, 8'h24, 8'h00, 8'h00};
	logic [7:0]  p2 [6] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h04, 8'h01};
	logic [7:0]  p3 [6] = '{8'h00, 8'h40, 8'h80, 8'h00, 8'h00, 8'h00};
	logic [7:0]  rstv [7] = '{`EACI_RST_CTL1, `EACI_RST_CTL2,
		`EACI_RST_CTL3, `EACI_RST_STAT, 8'h00, 8'h00, 8'h00};
	logic [15:0] tf [4] = '{16'h00ff, 16'h00fe, 16'h00ff, 16'hffff};
	logic [15:0] tt [4] = '{16'h0100, 16'h00ff, 16'h0100, 16'h0000};
	logic [7:0]  cpe [5] = '{8'h10, 8'h10, 8'h80, 8'h00, 8'h10};
	logic [7:0]  pe1 [5] = '{8'h88, 8'h88, 8'h88, 8'h88, 8'h80};
	int          pk [5] = '{4, 5, 7, 6, 4};

	eaci_top DUT
	(
		.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .port_b_pins, .timer_zero_count,
		.timer0_wide_mode, .cfg_mismatch_evt(evt[0]),
		.watchdog_timeout_evt(evt[1]), .watchdog_clear_evt(evt[2]),
		.power_down_evt(evt[3]), .core_sleeping, .vector_taken,
		.vector_is_high, .return_taken, .return_is_high, .return_pc,
		.core_ctx, .irq_high, .irq_low, .wake, .wake_vector, .fast_ctx,
		.stack_top, .stack_full, .irq
	);

	eaci_core_model core
	(
		.clk, .sys_rst, .irq_high, .irq_low, .wake, .sleep_req, .svc_en,
		.ret_req, .core_sleeping, .vector_taken, .vector_is_high,
		.return_taken, .return_is_high
	);

	always #50 clk = ~clk;

	always @(posedge clk)
	begin
		if (wake === 1'b1) nw++;
		if (wake === 1'b1 && wake_vector === 1'b1) nv++;
		if (vector_taken === 1'b1) nvt++;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	task automatic summarize;
		if (mismatches == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic apb(input logic w, input logic [7:0] a, d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		for (int k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, e);
		apb(1'b0, a, 8'h00);
		chk(nm, rd, {24'h0, e});
	endtask

	initial
	begin
		#10_000_000;
		mismatches++;
		summarize();
	end
// ****************************************
// Scenarios
// ****************************************
	initial
	begin
		cyc(20);
		sys_rst <= 1'b0;
		cyc(5);
		for (int i = 0; i < 7; i++) rdchk("reset", 4 * i, rstv[i]);
		apb(1'b0, 8'h40, 8'h00);
		chk("unmapped err", err, 1);
		chk("unmapped data", rd, 0);
		wr(`EACI_OFF_CPE, 8'hff);
		rdchk("cpe", `EACI_OFF_CPE, 8'hf0);
		m = `EACI_RST_STAT & ~`EACI_WM_STAT | 8'h20 & `EACI_WM_STAT;
		wr(`EACI_OFF_STAT, 8'h20);
		rdchk("stat ro", `EACI_OFF_STAT, m);
		for (int e = 0; e < 4; e++)
		begin
			evt <= 4'h1 << e;
			cyc(1);
			evt <= 4'h0;
			cyc(2);
			if (e == 0) m[5] = 1'b0;
			if (e == 1) m[3] = 1'b0;
			if (e == 2) m[3:2] = 2'b11;
			if (e == 3) m[3:2] = 2'b10;
			rdchk("stat event", `EACI_OFF_STAT, m);
		end
		wr(`EACI_OFF_STAT, m | 8'h20);
		rdchk("stat set", `EACI_OFF_STAT, m | 8'h20);
		wr(`EACI_OFF_IMSK, 8'h3f);
		for (int i = 0; i < 4; i++)
			for (int e = 0; e < 2; e++)
			begin
				wr(`EACI_OFF_CTL2, 8'h07 | (e << (6 - i)));
				port_b_pins[i] <= e;
				cyc(5);
				wr(`EACI_OFF_ISTS, 8'h3f);
				port_b_pins[i] <= !e;
				cyc(5);
				rdchk("wrong edge", `EACI_OFF_ISTS, 8'h00);
				port_b_pins[i] <= e;
				cyc(5);
				rdchk("edge", `EACI_OFF_ISTS, 8'h01 << i);
				chk("irq", irq, 1);
				wr(`EACI_OFF_IMSK, 8'h00);
				chk("irq masked", irq, 0);
				wr(`EACI_OFF_IMSK, 8'h3f);
				cyc(5);
				rdchk("sticky", `EACI_OFF_ISTS, 8'h01 << i);
				wr(`EACI_OFF_ISTS, 8'h3f);
				chk("irq clear", irq, 0);
			end
		for (int s = 0; s < 6; s++)
			for (int q = 0; q < 8; q++)
			begin
				wr(`EACI_OFF_STAT, q[2] ? 8'ha0 : 8'h20);
				wr(`EACI_OFF_CTL1, 8'hc0 | (q[0] ? m1[s] : m1[s] & 8'h07));
				wr(`EACI_OFF_CTL2, 8'h78 | (q[1] ? p2[s] : 8'h00));
				wr(`EACI_OFF_CTL3, (q[0] ? m3[s] : m3[s] & 8'h07)
					| (q[1] ? p3[s] : 8'h00));
				p = (s == 0) | q[1];
				eh = q[0] & (q[2] ? p : 1'b1);
				el = q[0] & q[2] & !p;
				chk("irq_high", irq_high, eh);
				chk("irq_low", irq_low, el);
			end
		wr(`EACI_OFF_CTL1, 8'h00);
		wr(`EACI_OFF_CTL3, 8'h00);
		wr(`EACI_OFF_STAT, 8'h20);
		for (int k = 0; k < 4; k++)
		begin
			timer0_wide_mode <= k >= 2;
			timer_zero_count <= tf[k];
			cyc(4);
			wr(`EACI_OFF_ISTS, 8'h3f);
			timer_zero_count <= tt[k];
			cyc(4);
			rdchk("timer", `EACI_OFF_ISTS, (k == 0 || k == 3) ? 8'h10 : 8'h00);
		end
		for (int k = 0; k < 5; k++)
		begin
			wr(`EACI_OFF_CPE, cpe[k]);
			wr(`EACI_OFF_CTL1, pe1[k]);
			wr(`EACI_OFF_ISTS, 8'h3f);
			port_b_pins <= port_b_pins ^ (8'h01 << pk[k]);
			cyc(5);
			rdchk("change", `EACI_OFF_ISTS, k[0] ? 8'h00 : 8'h20);
			chk("change irq", irq_high, k == 0 || k == 2);
		end
		port_b_pins[3:0] <= 4'h0;
		cyc(5);
		wr(`EACI_OFF_ISTS, 8'h3f);
		for (int g = 1; g >= 0; g--)
		begin
			wr(`EACI_OFF_CTL3, 8'h10);
			wr(`EACI_OFF_CTL1, g ? 8'h80 : 8'h00);
			sleep_req <= 1'b1;
			for (int k = 0; k < 20 && core_sleeping !== 1'b1; k++) cyc(1);
			sleep_req <= 1'b0;
			n0 = nw;
			v0 = nv;
			port_b_pins[3] <= 1'b1;
			cyc(6);
			chk("no wake", nw - n0, 0);
			port_b_pins[2] <= 1'b1;
			cyc(6);
			chk("wake", nw - n0, 1);
			chk("wake vector", nv - v0, g);
			port_b_pins[3:2] <= 2'b00;
			cyc(5);
			wr(`EACI_OFF_ISTS, 8'h3f);
		end
		wr(`EACI_OFF_CTL3, 8'h00);
		for (int r = 0; r < 2; r++)
		begin
			seed = xs(seed);
			return_pc <= seed[20:0];
			core_ctx <= seed[31:8];
			pc_exp = seed[20:0];
			ctx_exp = seed[31:8];
			wr(`EACI_OFF_CTL1, 8'h90);
			n0 = nvt;
			svc_en <= 1'b1;
			wr(`EACI_OFF_CTL1, 8'h92);
			for (int k = 0; k < 20 && nvt == n0; k++) cyc(1);
			svc_en <= 1'b0;
			cyc(2);
			chk("stack_top", stack_top, pc_exp);
			chk("fast_ctx", fast_ctx, ctx_exp);
			chk("stack_full", stack_full, 0);
			chk("gie cleared", irq_high, 0);
			wr(`EACI_OFF_CTL1, 8'h10);
			ret_req <= 1'b1;
			cyc(1);
			ret_req <= 1'b0;
			cyc(3);
			chk("stack pop", stack_top, 0);
		end
		summarize();
	end
endmodule // tb_edge_and_change_interrupt_sources
